// file: bench/host_model.sv
// Host model driving the register strobe port
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire mclk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire [7:0] reg_rdata
);
  // Idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One-cycle write strobe
  task wr(input [7:0] a, input [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // One-cycle read strobe, data taken after the edge
  task rd(input [7:0] a, output [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// file: bench/temp_result_proc_test.sv
// Self-checking bench for temperature result processing
`timescale 1ns/1ns
`default_nettype none
module temp_result_proc_test;
  logic mclk, arst_n, reg_wr, reg_rd, force_max_duty, frozen;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pwm1_max, v, d;
  logic [1:0] adc_chan;
  logic [2:0] temp_status;
  logic adc_valid = 1'b0, adc_fault = 1'b0, fault = 1'b0, auto_fan = 1'b0;
  logic [9:0] adc_data = 10'h000;
  logic [9:0] raw [0:2];
  logic [9:0] ex [0:2];
  logic [7:0] ofs [0:2];
  logic [39:0] dls = {8'hFF, 8'h02, 8'h05, 8'h02, 8'hFF};
  integer n_mismatch = 0, num_checks = 0, seed = 32'he4ef, i, nc;
  host_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  temp_result_proc #(.T_REM_AVG(40), .T_LC_AVG(30), .T_REM_FAST(20),
    .T_LC_FAST(10)) dut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .adc_chan(adc_chan), .adc_valid(adc_valid),
    .adc_data(adc_data), .adc_fault(adc_fault), .auto_fan_mode(auto_fan),
    .temp_status(temp_status), .force_max_duty(force_max_duty),
    .pwm1_max(pwm1_max), .pwm2_max(), .pwm3_max(), .frozen(frozen));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Converter source: one reading per cycle for the channel asked
  always @(posedge mclk) begin
    adc_valid <= 1'b1;
    adc_data <= raw[adc_chan];
    adc_fault <= fault;
  end
  // Expected value byte and fraction from raw reading and offset
  function [9:0] exp_val(input [9:0] r, input [7:0] o, input c, input f);
    integer t;
    begin
      t = $signed({1'b0, r}) + 2 * $signed(o); // Signed sum keeps offset sign
      if (t < 0) t = 0;
      if (t > 1023) t = 1023;
      if (f) exp_val = c ? 10'h200 : 10'h000;
      else if (c && t > 767) exp_val = 10'h1FC;
      else if (c) exp_val = t - 256;
      else exp_val = t;
    end
  endfunction
  // Expected reset contents
  function [7:0] rst_exp(input [7:0] a);
    case (a)
      8'h4E, 8'h50, 8'h52: rst_exp = 8'h01;
      8'h4F, 8'h51, 8'h53: rst_exp = 8'h7F;
      8'h6A, 8'h6B, 8'h6C: rst_exp = 8'h64;
      8'h6D, 8'h6E: rst_exp = 8'h44;
      8'h38, 8'h39, 8'h3A: rst_exp = 8'hFF;
      default: rst_exp = 8'h00;
    endcase
  endfunction
  // Comparisons
  task check8(input [7:0] got, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task check1(input got, input exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask
  task settle;
    repeat (100) @(posedge mclk);
  endtask
  task report_and_stop;
    begin
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // Length of a fresh slot of one channel, bounded waits
  task slot_cycles(input [1:0] ch, output integer n);
    integer k;
    begin
      k = 0;
      while (adc_chan === ch && k < 400) begin
        @(posedge mclk);
        k = k + 1;
      end
      while (adc_chan !== ch && k < 400) begin
        @(posedge mclk);
        k = k + 1;
      end
      n = 0;
      while (adc_chan === ch && n < 400) begin
        @(posedge mclk);
        n = n + 1;
      end
      if (k >= 400 || n >= 400) begin
        n_mismatch = n_mismatch + 1;
        report_and_stop;
      end
    end
  endtask
  // Watchdog
  initial begin
    repeat (100000) @(posedge mclk);
    n_mismatch = n_mismatch + 1;
    report_and_stop;
  end
  // Main sequence
  initial begin
    for (i = 0; i < 3; i = i + 1) raw[i] = 10'h100;
    arst_n = 1'b0;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    for (i = 8'h38; i < 8'h77; i = i + 1) begin
      host.rd(i[7:0], d);
      check8(d, rst_exp(i[7:0]));
    end
    host.rd(8'h01, d);
    check8(d, 8'h00);
    check8(pwm1_max, 8'hFF);
    // Keep remote 1 and local out of the boost test
    host.wr(8'h6A, 8'hFF);
    host.wr(8'h6B, 8'hFF);
    for (i = 0; i < 3; i = i + 1) begin
      raw[i] = 10'h180 + ($random(seed) & 10'h0FF);
      ofs[i] = ($random(seed) & 8'h3F) - 8'h20;
      host.wr(8'h70 + i[7:0], ofs[i]);
      host.wr(8'h55, {3'h5 + i[2:0], 5'h00});
      host.wr(8'h73, (i == 1) ? 8'h40 : 8'h50);
      settle;
      ex[i] = exp_val(raw[i], ofs[i], 1'b0, 1'b0);
      host.rd(8'h25 + i[7:0], d);
      check8(d, ex[i][9:2]);
    end
    host.rd(8'h77, d);
    check1(frozen, 1'b1);
    check8(d, {ex[2][1:0], ex[1][1:0], ex[0][1:0], 2'b00});
    raw[2] = raw[2] + 10'h040;
    settle;
    host.rd(8'h27, d);
    check8(d, ex[2][9:2]);
    host.rd(8'h25, d);
    host.rd(8'h26, d);
    check1(frozen, 1'b0);
    settle;
    ex[2] = exp_val(raw[2], ofs[2], 1'b0, 1'b0);
    host.rd(8'h27, d);
    check8(d, ex[2][9:2]);
    host.wr(8'h7C, 8'h02);
    settle;
    host.rd(8'h27, d);
    check8(d, exp_val(raw[2], ofs[2], 1'b1, 1'b0) >> 2);
    @(posedge mclk) fault <= 1'b1;
    settle;
    host.rd(8'h27, d);
    check8(d, 8'h80);
    host.wr(8'h4E, 8'h80);
    host.rd(8'h4E, d);
    check8(d, 8'hC1);
    host.wr(8'h7C, 8'h00);
    settle;
    host.rd(8'h27, d);
    check8(d, 8'h00);
    @(posedge mclk) fault <= 1'b0;
    settle;
    v = ex[2][9:2];
    for (i = 0; i < 4; i = i + 1) begin
      host.wr(8'h53, (i == 0) ? v - 8'h01 : v);
      host.wr(8'h52, (i == 2) ? v : ((i == 3) ? v - 8'h01 : 8'h01));
      settle;
      check1(temp_status[2], i == 0 || i == 2);
    end
    @(posedge mclk) auto_fan <= 1'b1;
    for (i = 0; i < 5; i = i + 1) begin
      host.wr(8'h6C, v + dls[8 * i +: 8]);
      settle;
      check1(force_max_duty, 5'b10011 >> i);
    end
    host.wr(8'h78, 8'h04);
    settle;
    check1(force_max_duty, 1'b0);
    for (i = 0; i < 3; i = i + 1) begin
      v = $random(seed);
      host.wr(8'h38 + i[7:0], v);
      host.rd(8'h38 + i[7:0], d);
      check8(d, v);
    end
    // Round robin slot lengths, bench values 10/20 fast, 30/40 averaged
    host.wr(8'h73, 8'h10);
    slot_cycles(2'd1, nc);
    check8(nc[7:0], 8'h0A);
    check8({6'h00, adc_chan}, 8'h02);
    slot_cycles(2'd2, nc);
    check8(nc[7:0], 8'h14);
    host.wr(8'h73, 8'h00);
    slot_cycles(2'd1, nc);
    check8(nc[7:0], 8'h1E);
    slot_cycles(2'd0, nc);
    check8(nc[7:0], 8'h28);
    check8({6'h00, adc_chan}, 8'h01);
    report_and_stop;
  end
endmodule
`default_nettype wire

// file: bench/temp_result_properties.sv
// Checker for register port, freeze and max-duty outputs
`timescale 1ns/1ns
`default_nettype none
module temp_result_props (
  input wire mclk,
  input wire arst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [1:0] adc_chan,
  input wire [2:0] temp_status,
  input wire force_max_duty,
  input wire [7:0] pwm1_max,
  input wire [7:0] pwm2_max,
  input wire [7:0] pwm3_max,
  input wire frozen
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Freeze start, hold and release
  freeze_start_a: assert property (reg_rd && reg_addr == 8'h77 |=> frozen)
    else $error("freeze did not start");
  freeze_hold_a: assert property (frozen && !reg_rd |=> frozen)
    else $error("freeze dropped without a read");
  freeze_end_a: assert property ($fell(frozen) |-> $past(reg_rd))
    else $error("freeze ended without a read");
  // Read data only moves on a read, unmapped reads return zero
  read_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  unmapped_read_a: assert property (reg_rd && reg_addr == 8'h01 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  // Maximum duty registers reach their ports, pwm1 maximum reads back, conversion channel stays legal
  pwm1_write_a: assert property (reg_wr && reg_addr == 8'h38 |=> pwm1_max == $past(reg_wdata))
    else $error("pwm1 max not written");
  pwm2_write_a: assert property (reg_wr && reg_addr == 8'h39 |=> pwm2_max == $past(reg_wdata))
    else $error("pwm2 max not written");
  pwm3_write_a: assert property (reg_wr && reg_addr == 8'h3A |=> pwm3_max == $past(reg_wdata))
    else $error("pwm3 max not written");
  pwm_readback_a: assert property (reg_rd && !reg_wr && reg_addr == 8'h38 |=> reg_rdata == pwm1_max)
    else $error("pwm1 max readback wrong");
  chan_legal_a: assert property (adc_chan != 2'h3)
    else $error("illegal conversion channel");
  // Main scenarios
  freeze_c: cover property ($rose(frozen));
  boost_c: cover property ($rose(force_max_duty));
  status_c: cover property (temp_status != 3'h0);
endmodule
bind temp_result_proc temp_result_props props (.mclk(mclk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .adc_chan(adc_chan), .temp_status(temp_status),
  .force_max_duty(force_max_duty), .pwm1_max(pwm1_max), .pwm2_max(pwm2_max),
  .pwm3_max(pwm3_max), .frozen(frozen));
`default_nettype wire

// file: design/temp_result_proc.v
// Temperature result processing: offset, format, freeze, limits and boost
`timescale 1ns/1ns
`default_nettype none
`include "temp_result_defs.vh"
// What this block does
// RULE1: Per-channel offset registers for remote 1, local and remote 2.
// RULE2: Offset is signed 8-bit, half-degree steps, plus or minus 64 degrees.
// RULE3: Compatibility bit stores two's complement, clamped -64 to +127.
// RULE4: In compatibility mode limits below -63 are clamped to -63.
// RULE5: Diode fault reads 0x80 in compatibility mode, 0x00 otherwise.
// RULE6: Integer results sit at 0x25, 0x26, 0x27 in channel order.
// RULE7: Fraction register holds remote 2, local, remote 1 quarter bits.
// RULE8: Fraction read freezes value registers until all three are read.
// RULE9: Host reads fraction first, then all value registers.
// RULE10: Integer-only reads allowed any time, any order.
// RULE11: High and low limit per channel set the channel status bit.
// RULE12: Averaging takes sixteen readings and averages them.
// RULE13: Averaging-off bit stores a single conversion.
// RULE14: Unaveraged times: remote 7 ms, local 1.3 ms.
// RULE15: Averaged times: remote 39 ms, local 12 ms.
// RULE16: Single-channel bit repeats one selected channel.
// RULE17: Select codes 101 remote 1, 110 local, 111 remote 2.
// RULE18: Overtemperature in auto fan mode forces maximum duty.
// RULE19: Force holds until below limit minus hysteresis, default 4.
// RULE20: Boost-disable bit inhibits the forced maximum duty.
// RULE21: Extended range encodes with offset 64.
// RULE22: High violation is greater than; low is less or equal.
// RULE23: Channels convert round robin, updating unless frozen.
module temp_result_proc #(
  parameter T_REM_AVG = `T_REM_AVG_US * `CLK_MHZ,
  parameter T_LC_AVG = `T_LC_AVG_US * `CLK_MHZ,
  parameter T_REM_FAST = `T_REM_FAST_US * `CLK_MHZ,
  parameter T_LC_FAST = `T_LC_FAST_US * `CLK_MHZ
) (
  input wire mclk,
  input wire arst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg [1:0] adc_chan,
  input wire adc_valid,
  input wire [9:0] adc_data,
  input wire adc_fault,
  input wire auto_fan_mode,
  output reg [2:0] temp_status,
  output wire force_max_duty,
  output wire [7:0] pwm1_max,
  output wire [7:0] pwm2_max,
  output wire [7:0] pwm3_max,
  output wire frozen
);
  // Value registers and their fraction pairs
  reg [7:0] val_r [0:2];
  reg [1:0] frac_r [0:2];
  reg [7:0] low_r [0:2];
  reg [7:0] high_r [0:2];
  reg [7:0] ovt_r [0:2];
  reg [7:0] ofs_r [0:2];
  reg [7:0] duty_r [0:2];
  reg [7:0] hyst_a_r;
  reg [7:0] hyst_b_r;
  reg [7:0] fan_sel_r;
  reg [7:0] cfg2_r;
  reg [7:0] cfg3_r;
  reg [7:0] cfg5_r;
  reg freeze_r;
  reg [2:0] seen_r;
  reg [2:0] boost_r;
  reg [23:0] tmr_r;
  reg [13:0] acc_r;
  reg [4:0] cnt_r;
  reg [9:0] last_r;
  reg fault_r;
  integer i;
  integer k;

  wire compat = cfg5_r[`CFG5_COMPAT];
  wire avg_off = cfg2_r[`CFG2_AVG_OFF];
  wire single = cfg2_r[`CFG2_SINGLE];

  // Sign or zero extension for comparisons
  function [9:0] ext10;
    input [7:0] v;
    input sgn;
    begin
      ext10 = sgn ? {{2{v[7]}}, v} : {2'b00, v};
    end
  endfunction

  // Greater-than in the active number format
  function gt8;
    input [7:0] a;
    input [7:0] b;
    input sgn;
    begin
      gt8 = $signed(ext10(a, sgn)) > $signed(ext10(b, sgn));
    end
  endfunction

  // Below limit minus hysteresis in the active number format
  function below_hyst;
    input [7:0] t;
    input [7:0] lim;
    input [3:0] h;
    input sgn;
    begin
      below_hyst = $signed(ext10(t, sgn)) <
        ($signed(ext10(lim, sgn)) - $signed({6'b000000, h}));
    end
  endfunction

  // Limit clamp applied at write time in compatibility mode
  function [7:0] lim_in;
    input [7:0] d;
    input sgn;
    begin
      if (sgn && $signed(d) < $signed(`COMPAT_MIN_LIM))
        lim_in = `COMPAT_MIN_LIM; // RULE4
      else
        lim_in = d;
    end
  endfunction

  // Hysteresis nibble for a channel
  function [3:0] hyst_of;
    input [1:0] ch;
    input [7:0] ha;
    input [7:0] hb;
    begin
      case (ch)
        2'd0: hyst_of = ha[7:4];
        2'd1: hyst_of = ha[3:0];
        default: hyst_of = hb[7:4];
      endcase
    end
  endfunction

  // Slot length by channel and averaging
  reg [23:0] slot_len;
  always @* begin
    if (adc_chan == 2'd1)
      slot_len = avg_off ? T_LC_FAST[23:0] : T_LC_AVG[23:0]; // RULE14 RULE15
    else
      slot_len = avg_off ? T_REM_FAST[23:0] : T_REM_AVG[23:0]; // RULE14 RULE15
  end
  wire slot_end = (tmr_r >= slot_len - 24'd1);

  // Channel picked in single mode
  reg [1:0] sel_ch;
  always @* begin
    case (fan_sel_r[7:5])
      `SEL_R1: sel_ch = 2'd0; // RULE17
      `SEL_LC: sel_ch = 2'd1; // RULE17
      `SEL_R2: sel_ch = 2'd2; // RULE17
      default: sel_ch = 2'd0;
    endcase
  end

  // Next channel: round robin or fixed
  reg [1:0] next_ch;
  always @* begin
    if (single)
      next_ch = sel_ch; // RULE16
    else if (adc_chan == 2'd2)
      next_ch = 2'd0; // RULE23
    else
      next_ch = adc_chan + 2'd1; // RULE23
  end

  // Raw result: average of sixteen or single reading
  wire [9:0] raw = avg_off ? last_r : acc_r[13:4]; // RULE12 RULE13

  // Offset in quarter degrees added to the raw reading
  reg [7:0] cur_ofs;
  reg [11:0] sum;
  reg [9:0] adj;
  reg [7:0] new_val;
  reg [1:0] new_frac;
  always @* begin
    cur_ofs = ofs_r[adc_chan];
    sum = {2'b00, raw} + {{3{cur_ofs[7]}}, cur_ofs, 1'b0}; // RULE1 RULE2
    if (sum[11])
      adj = 10'h000;
    else if (sum[10])
      adj = 10'h3FF;
    else
      adj = sum[9:0];
    new_frac = adj[1:0]; // RULE7
    if (fault_r) begin
      new_val = compat ? `FAULT_COMPAT : `FAULT_EXT; // RULE5
      new_frac = 2'b00;
    end else if (!compat) begin
      new_val = adj[9:2]; // RULE21
    end else if (adj[9:2] > 8'hBF) begin
      new_val = `COMPAT_MAX; // RULE3
      new_frac = 2'b00;
    end else begin
      new_val = adj[9:2] - 8'h40; // RULE3
    end
  end

  // Limit tests on the fresh result
  wire [1:0] c = adc_chan;
  wire hi_hit = gt8(new_val, high_r[c], compat); // RULE22
  wire lo_hit = !gt8(new_val, low_r[c], compat); // RULE22
  wire ovt_hit = gt8(new_val, ovt_r[c], compat);
  wire ovt_clr = below_hyst(new_val, ovt_r[c],
    hyst_of(c, hyst_a_r, hyst_b_r), compat);

  // Conversion sequencer, sample accumulation and result store
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      adc_chan <= 2'd0;
      tmr_r <= 24'd0;
      acc_r <= 14'd0;
      cnt_r <= 5'd0;
      last_r <= 10'd0;
      fault_r <= 1'b0;
      temp_status <= 3'b000;
      boost_r <= 3'b000;
      for (i = 0; i < 3; i = i + 1) begin
        val_r[i] <= `RST_ZERO;
        frac_r[i] <= 2'b00;
      end
    end else if (slot_end) begin
      tmr_r <= 24'd0;
      acc_r <= 14'd0;
      cnt_r <= 5'd0;
      fault_r <= 1'b0;
      adc_chan <= next_ch;
      if (!freeze_r) begin
        val_r[c] <= new_val; // RULE6 RULE23 RULE8
        frac_r[c] <= new_frac; // RULE7
      end
      temp_status[c] <= hi_hit | lo_hit; // RULE11
      if (!fault_r) begin
        if (ovt_hit)
          boost_r[c] <= 1'b1; // RULE18
        else if (ovt_clr)
          boost_r[c] <= 1'b0; // RULE19
      end
    end else begin
      tmr_r <= tmr_r + 24'd1;
      if (adc_valid) begin
        last_r <= adc_data;
        if (adc_fault)
          fault_r <= 1'b1;
        if (cnt_r < `AVG_SAMPLES) begin
          acc_r <= acc_r + {4'h0, adc_data}; // RULE12
          cnt_r <= cnt_r + 5'd1;
        end
      end
    end
  end

  // Boost output gated by auto mode and the disable bit
  assign force_max_duty = auto_fan_mode & ~cfg3_r[`CFG3_BOOST_DIS] &
    (|boost_r); // RULE18 RULE20
  assign pwm1_max = duty_r[0];
  assign pwm2_max = duty_r[1];
  assign pwm3_max = duty_r[2];
  assign frozen = freeze_r;

  // Read hits on value registers
  reg [2:0] val_hit;
  always @* begin
    val_hit = 3'b000;
    if (reg_rd) begin
      val_hit[0] = (reg_addr == `A_R1_VAL);
      val_hit[1] = (reg_addr == `A_LC_VAL);
      val_hit[2] = (reg_addr == `A_R2_VAL);
    end
  end

  // Freeze control: fraction read starts, all three value reads end it
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      freeze_r <= 1'b0;
      seen_r <= 3'b000;
    end else if (reg_rd && reg_addr == `A_FRAC) begin
      freeze_r <= 1'b1; // RULE8
      seen_r <= 3'b000;
    end else if (freeze_r) begin
      if ((seen_r | val_hit) == 3'b111) begin
        freeze_r <= 1'b0; // RULE8 RULE9
        seen_r <= 3'b000;
      end else begin
        seen_r <= seen_r | val_hit;
      end
    end
  end

  // Register writes
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (k = 0; k < 3; k = k + 1) begin
        low_r[k] <= `RST_LOW_LIM;
        high_r[k] <= `RST_HIGH_LIM;
        ovt_r[k] <= `RST_OVT_LIM;
        ofs_r[k] <= `RST_ZERO;
        duty_r[k] <= `RST_MAX_DUTY;
      end
      hyst_a_r <= `RST_HYST;
      hyst_b_r <= `RST_HYST;
      fan_sel_r <= `RST_ZERO;
      cfg2_r <= `RST_ZERO;
      cfg3_r <= `RST_ZERO;
      cfg5_r <= `RST_ZERO;
    end else if (reg_wr) begin
      case (reg_addr)
        `A_PWM1_MAX: duty_r[0] <= reg_wdata;
        `A_PWM2_MAX: duty_r[1] <= reg_wdata;
        `A_PWM3_MAX: duty_r[2] <= reg_wdata;
        `A_R1_LOW: low_r[0] <= lim_in(reg_wdata, compat); // RULE4
        `A_R1_HIGH: high_r[0] <= lim_in(reg_wdata, compat);
        `A_LC_LOW: low_r[1] <= lim_in(reg_wdata, compat);
        `A_LC_HIGH: high_r[1] <= lim_in(reg_wdata, compat);
        `A_R2_LOW: low_r[2] <= lim_in(reg_wdata, compat);
        `A_R2_HIGH: high_r[2] <= lim_in(reg_wdata, compat);
        `A_FAN1_MIN_HI: fan_sel_r <= reg_wdata;
        `A_R1_OVT: ovt_r[0] <= lim_in(reg_wdata, compat);
        `A_LC_OVT: ovt_r[1] <= lim_in(reg_wdata, compat);
        `A_R2_OVT: ovt_r[2] <= lim_in(reg_wdata, compat);
        `A_HYST_A: hyst_a_r <= reg_wdata;
        `A_HYST_B: hyst_b_r <= reg_wdata;
        `A_R1_OFS: ofs_r[0] <= reg_wdata; // RULE1
        `A_LC_OFS: ofs_r[1] <= reg_wdata; // RULE1
        `A_R2_OFS: ofs_r[2] <= reg_wdata; // RULE1
        `A_CFG2: cfg2_r <= reg_wdata;
        `A_CFG3: cfg3_r <= reg_wdata;
        `A_CFG5: cfg5_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data, one cycle after the read strobe
  reg [7:0] rd_nxt;
  always @* begin
    case (reg_addr)
      `A_R1_VAL: rd_nxt = val_r[0]; // RULE6 RULE10
      `A_LC_VAL: rd_nxt = val_r[1]; // RULE6 RULE10
      `A_R2_VAL: rd_nxt = val_r[2]; // RULE6 RULE10
      `A_PWM1_MAX: rd_nxt = duty_r[0];
      `A_PWM2_MAX: rd_nxt = duty_r[1];
      `A_PWM3_MAX: rd_nxt = duty_r[2];
      `A_R1_LOW: rd_nxt = low_r[0];
      `A_R1_HIGH: rd_nxt = high_r[0];
      `A_LC_LOW: rd_nxt = low_r[1];
      `A_LC_HIGH: rd_nxt = high_r[1];
      `A_R2_LOW: rd_nxt = low_r[2];
      `A_R2_HIGH: rd_nxt = high_r[2];
      `A_FAN1_MIN_HI: rd_nxt = fan_sel_r;
      `A_R1_OVT: rd_nxt = ovt_r[0];
      `A_LC_OVT: rd_nxt = ovt_r[1];
      `A_R2_OVT: rd_nxt = ovt_r[2];
      `A_HYST_A: rd_nxt = hyst_a_r;
      `A_HYST_B: rd_nxt = hyst_b_r;
      `A_R1_OFS: rd_nxt = ofs_r[0];
      `A_LC_OFS: rd_nxt = ofs_r[1];
      `A_R2_OFS: rd_nxt = ofs_r[2];
      `A_CFG2: rd_nxt = cfg2_r;
      `A_FRAC: rd_nxt = {frac_r[2], frac_r[1], frac_r[0], 2'b00}; // RULE7
      `A_CFG3: rd_nxt = cfg3_r;
      `A_CFG5: rd_nxt = cfg5_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_nxt;
  end
endmodule
`default_nettype wire

// file: pkg/temp_result_defs.vh
// Register offsets, field positions, reset values and timing for temp results
`ifndef TEMP_RESULT_DEFS_VH
`define TEMP_RESULT_DEFS_VH
`define A_R1_VAL 8'h25
`define A_LC_VAL 8'h26
`define A_R2_VAL 8'h27
`define A_PWM1_MAX 8'h38
`define A_PWM2_MAX 8'h39
`define A_PWM3_MAX 8'h3A
`define A_R1_LOW 8'h4E
`define A_R1_HIGH 8'h4F
`define A_LC_LOW 8'h50
`define A_LC_HIGH 8'h51
`define A_R2_LOW 8'h52
`define A_R2_HIGH 8'h53
`define A_FAN1_MIN_HI 8'h55
`define A_R1_OVT 8'h6A
`define A_LC_OVT 8'h6B
`define A_R2_OVT 8'h6C
`define A_HYST_A 8'h6D
`define A_HYST_B 8'h6E
`define A_R1_OFS 8'h70
`define A_LC_OFS 8'h71
`define A_R2_OFS 8'h72
`define A_CFG2 8'h73
`define A_FRAC 8'h77
`define A_CFG3 8'h78
`define A_CFG5 8'h7C
// Field positions
`define CFG2_AVG_OFF 4
`define CFG2_SINGLE 6
`define CFG3_BOOST_DIS 2
`define CFG5_COMPAT 1
// Reset values
`define RST_LOW_LIM 8'h01
`define RST_HIGH_LIM 8'h7F
`define RST_OVT_LIM 8'h64
`define RST_HYST 8'h44
`define RST_MAX_DUTY 8'hFF
`define RST_ZERO 8'h00
// Channel select codes in the fan1 minimum high byte
`define SEL_R1 3'h5
`define SEL_LC 3'h6
`define SEL_R2 3'h7
// Codes
`define FAULT_COMPAT 8'h80
`define FAULT_EXT 8'h00
`define COMPAT_MAX 8'h7F
`define COMPAT_MIN_LIM 8'hC1
// Conversion times in microseconds, clock rate in MHz and averaging sample count
`define T_REM_AVG_US 39000
`define T_LC_AVG_US 12000
`define T_REM_FAST_US 7000
`define T_LC_FAST_US 1300
`define T_VOLT_AVG_US 11000
`define T_VOLT_FAST_US 700
`define CLK_MHZ 250
`define AVG_SAMPLES 16
`endif
